// ---- hdl/gw_gateway.sv ----
// Gateway end: latches front-panel switches after reset, routes master bits
// to drivers, answers commands and drives the error indicators.
// Assumes switch, error and NV pins are asynchronous; DRV_STATUS is on MCLK.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module gw_gateway
    import gw_cfg_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    gw_link_if.gateway LINK,
    input wire logic [3:0] SERIAL_RATE_SW,
    input wire logic [3:0] AXIS_MODE_SW,
    input wire logic [3:0] STATION_TENS_SW,
    input wire logic [3:0] STATION_ONES_SW,
    input wire logic [3:0] FIELD_RATE_SW,
    input wire logic TERMINATION_SW,
    input wire logic RS485_ERR,
    input wire logic NV_CONN_IN,
    input wire logic [15:0] DRV_STATUS,
    output logic SERIAL_RATE_OK,
    output logic SWITCH_ALARM,
    output logic AXIS12_MODE,
    output logic [3:0] MAX_DRIVERS,
    output logic [4:0] POINTS_PER_DRIVER,
    output logic [6:0] STATION_NUM,
    output logic STATION_OK,
    output logic [2:0] FIELD_RATE,
    output logic FIELD_RATE_OK,
    output logic TERM_EN,
    output logic CONN_EN0,
    output logic CONFIG_DONE,
    output logic DRV_WR,
    output logic [3:0] DRV_ADDR,
    output logic [15:0] DRV_BITS,
    output logic [15:0] GW_CTRL,
    output logic NV_WRITE,
    output logic NV_CONN_OUT,
    output logic SERIAL_ERR_LED,
    output logic LINK_ERR_LED
);
    function automatic logic digit_ok(input logic [3:0] d);
        digit_ok = (d <= DIGIT_MAX);
    endfunction : digit_ok

    function automatic logic [6:0] station_of(input logic [3:0] t, input logic [3:0] o);
        station_of = 7'(t) * 7'd10 + 7'(o);
    endfunction : station_of

    logic [SW_BITS-1:0] pins;
    logic [SW_BITS-1:0] sw;
    assign pins = {NV_CONN_IN, RS485_ERR, TERMINATION_SW, FIELD_RATE_SW,
        STATION_ONES_SW, STATION_TENS_SW, AXIS_MODE_SW, SERIAL_RATE_SW};

    genvar gi;
    generate
        for (gi = 0; gi < SW_BITS; gi++) begin : g_sync
            gw_sync3 u_sync (
                .clk(MCLK),
                .rst(SYS_RST),
                .d(pins[gi]),
                .q(sw[gi])
            );
        end
    endgenerate

    // Boot sequencer: wait for synchronisers to settle, then latch once
    boot_e state;
    boot_e next_state;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic latch;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        latch = 1'b0;
        case (state)
            BOOT_HOLD: begin
                next_state = BOOT_SETTLE;
                next_cnt = 3'h0;
            end
            BOOT_SETTLE: begin
                next_cnt = cnt + 3'h1;
                if (cnt == SETTLE_CYCLES - 3'h1) begin
                    next_state = BOOT_RUN;
                    latch = 1'b1; // [RL17]
                end
            end
            default: next_state = BOOT_RUN;
        endcase
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= BOOT_HOLD;
            cnt <= 3'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Configuration latch
    logic [3:0] ser;
    logic [6:0] stn;
    logic [6:0] next_stn;
    logic next_stn_ok;
    logic [9:0] io_base;
    logic [9:0] next_io_base;

    always_comb begin
        next_stn = station_of(sw[11:8], sw[15:12]); // [RL8]
        next_stn_ok = digit_ok(sw[11:8]) && digit_ok(sw[15:12])
            && next_stn >= STATION_MIN && next_stn <= STATION_MAX; // [RL9]
        next_io_base = next_stn_ok ? {next_stn - STATION_MIN, 3'b000} : 10'h000; // [RL13]
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ser <= SER_RATE_RST;
            SERIAL_RATE_OK <= 1'b0;
            SWITCH_ALARM <= 1'b0;
            AXIS12_MODE <= 1'b0;
            MAX_DRIVERS <= DRIVERS_6AX;
            POINTS_PER_DRIVER <= POINTS_6AX;
            stn <= STATION_RST;
            STATION_OK <= 1'b0;
            io_base <= 10'h000;
            FIELD_RATE <= FIELD_RATE_RST;
            FIELD_RATE_OK <= 1'b0;
            TERM_EN <= 1'b1;
            CONN_EN0 <= 1'b0;
            CONFIG_DONE <= 1'b0;
        end else if (latch) begin // [RL4]
            ser <= sw[3:0];
            SERIAL_RATE_OK <= (sw[3:0] == SER_RATE_625K); // [RL1]
            SWITCH_ALARM <= (sw[3:0] >= SER_RATE_BAD); // [RL2] [RL3]
            AXIS12_MODE <= sw[4]; // [RL7]
            MAX_DRIVERS <= sw[4] ? DRIVERS_12AX : DRIVERS_6AX; // [RL5] [RL6]
            POINTS_PER_DRIVER <= sw[4] ? POINTS_12AX : POINTS_6AX; // [RL5] [RL6]
            stn <= next_stn;
            STATION_OK <= next_stn_ok;
            io_base <= next_io_base;
            FIELD_RATE <= sw[18:16]; // [RL10]
            FIELD_RATE_OK <= (sw[19:16] <= FIELD_RATE_MAX); // [RL10]
            TERM_EN <= sw[20];
            CONN_EN0 <= sw[22]; // [RL14]
            CONFIG_DONE <= 1'b1;
        end
    end

    assign STATION_NUM = stn;
    assign LINK.station = stn;
    assign LINK.io_base = io_base;
    assign LINK.cfg_ok = STATION_OK;
    assign LINK.axis12 = AXIS12_MODE;
    assign LINK.sw_alarm = SWITCH_ALARM;

    // Master bit routing; in 12-axis mode each driver word (index below 6) feeds two drivers
    logic take;
    logic ry_ready;
    logic pend;
    logic [3:0] pend_addr;
    logic [7:0] pend_bits;
    logic next_ry_ready;
    logic next_pend;
    logic [3:0] next_pend_addr;
    logic [7:0] next_pend_bits;
    logic next_drv_wr;
    logic [3:0] next_drv_addr;
    logic [15:0] next_drv_bits;
    logic [15:0] next_gw_ctrl;
    logic next_rx_valid;
    logic [2:0] next_rx_index;
    logic [15:0] next_rx_bits;
    logic [15:0] gw_status;

    assign take = LINK.ry_valid && ry_ready;
    assign gw_status = {11'h000, LINK_ERR_LED, SERIAL_ERR_LED, CONN_EN0, AXIS12_MODE,
        SWITCH_ALARM};

    always_comb begin
        next_pend = pend;
        next_pend_addr = pend_addr;
        next_pend_bits = pend_bits;
        next_drv_wr = 1'b0;
        next_drv_addr = DRV_ADDR;
        next_drv_bits = DRV_BITS;
        next_gw_ctrl = GW_CTRL;
        next_rx_valid = 1'b0;
        next_rx_index = LINK.rx_index;
        next_rx_bits = LINK.rx_bits;
        if (pend) begin
            next_drv_wr = 1'b1;
            next_drv_addr = pend_addr;
            next_drv_bits = {8'h00, pend_bits};
            next_pend = 1'b0;
        end else if (take) begin
            next_rx_valid = 1'b1;
            next_rx_index = LINK.ry_index;
            next_rx_bits = 16'h0000;
            if (LINK.ry_index < IDX_GATEWAY) begin
                next_drv_wr = 1'b1;
                next_rx_bits = DRV_STATUS;
                if (AXIS12_MODE) begin // [RL6]
                    next_drv_addr = {LINK.ry_index, 1'b0};
                    next_drv_bits = {8'h00, LINK.ry_bits[7:0]};
                    next_pend = 1'b1;
                    next_pend_addr = {LINK.ry_index, 1'b1};
                    next_pend_bits = LINK.ry_bits[15:8];
                end else begin // [RL5]
                    next_drv_addr = {1'b0, LINK.ry_index};
                    next_drv_bits = LINK.ry_bits; // [RL12]
                end
            end else if (LINK.ry_index == IDX_GATEWAY) begin
                next_gw_ctrl = LINK.ry_bits; // [RL12]
                next_rx_bits = gw_status;
            end
        end
        next_ry_ready = (next_state == BOOT_RUN) && STATION_OK && !next_pend; // [RL9]
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ry_ready <= 1'b0;
            pend <= 1'b0;
            pend_addr <= 4'h0;
            pend_bits <= 8'h00;
            DRV_WR <= 1'b0;
            DRV_ADDR <= 4'h0;
            DRV_BITS <= 16'h0000;
            GW_CTRL <= 16'h0000;
            LINK.rx_valid <= 1'b0;
            LINK.rx_index <= 3'h0;
            LINK.rx_bits <= 16'h0000;
        end else begin
            ry_ready <= next_ry_ready;
            pend <= next_pend;
            pend_addr <= next_pend_addr;
            pend_bits <= next_pend_bits;
            DRV_WR <= next_drv_wr;
            DRV_ADDR <= next_drv_addr;
            DRV_BITS <= next_drv_bits;
            GW_CTRL <= next_gw_ctrl;
            LINK.rx_valid <= next_rx_valid;
            LINK.rx_index <= next_rx_index;
            LINK.rx_bits <= next_rx_bits;
        end
    end

    assign LINK.ry_ready = ry_ready;

    // Commands: volatile parameter write and batch save to NV store
    logic conn_vol;
    logic next_conn_vol;
    logic next_nv_write;
    logic next_nv_conn_out;
    logic next_cmd_ok;

    always_comb begin
        next_conn_vol = conn_vol;
        next_nv_write = 1'b0;
        next_nv_conn_out = NV_CONN_OUT;
        next_cmd_ok = 1'b0;
        if (LINK.cmd_valid) begin
            if (LINK.cmd_code == CMD_CONN0) begin
                next_conn_vol = (LINK.cmd_data == 16'h0001); // [RL14]
                next_cmd_ok = 1'b1;
            end else if (LINK.cmd_code == CMD_NV_BATCH) begin
                next_nv_write = 1'b1; // [RL15]
                next_nv_conn_out = conn_vol;
                next_cmd_ok = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            conn_vol <= 1'b0;
            NV_WRITE <= 1'b0;
            NV_CONN_OUT <= 1'b0;
            LINK.cmd_done <= 1'b0;
            LINK.cmd_ok <= 1'b0;
            SERIAL_ERR_LED <= 1'b0;
            LINK_ERR_LED <= 1'b0;
        end else begin
            conn_vol <= next_conn_vol;
            NV_WRITE <= next_nv_write;
            NV_CONN_OUT <= next_nv_conn_out;
            LINK.cmd_done <= LINK.cmd_valid;
            LINK.cmd_ok <= next_cmd_ok;
            SERIAL_ERR_LED <= sw[21]; // [RL16]
            LINK_ERR_LED <= LINK.link_fault; // [RL16]
        end
    end
endmodule : gw_gateway

// ---- common/gw_cfg_pkg.sv ----
// Constants, codes and types shared by the gateway end and the master end.
// Assumes both ends run on MCLK and share SYS_RST.
// Notes on behaviour
// RL1: Serial switch 7 gives 625 kbps, default
// RL2: Serial switch 8 or more raises alarm
// RL3: Serial switch 0 to 6 unusable, no alarm
// RL4: Switches read only at power-up
// RL5: Mode off: six drivers, 16 points each
// RL6: Mode on: twelve drivers, eight points each
// RL7: Mode positions 2 to 4 ignored
// RL8: Station is tens digit times ten plus ones
// RL9: Station valid 01 to 64, default 1
// RL10: Fieldbus rate codes 0 to 4, rest unused
// RL11: Installer keeps RS-485 termination switched on
// RL12: Remote I/O point reads 1 when on
// RL13: I/O base index follows station number
// RL14: Connection enable 1D80h applies after power cycle
// RL15: Fieldbus data volatile until batch save 3E85h
// RL16: Serial and link error indicators kept separate
// RL17: Switch values latched after reset, held
package gw_cfg_pkg;
    localparam logic [3:0] SER_RATE_625K = 4'h7;
    localparam logic [3:0] SER_RATE_BAD = 4'h8;
    localparam logic [3:0] SER_RATE_RST = 4'h7;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [6:0] STATION_MIN = 7'h01;
    localparam logic [6:0] STATION_MAX = 7'h40;
    localparam logic [6:0] STATION_RST = 7'h01;
    localparam logic [3:0] FIELD_RATE_MAX = 4'h4;
    localparam logic [2:0] FIELD_RATE_RST = 3'h0;
    localparam logic [4:0] POINTS_6AX = 5'h10;
    localparam logic [4:0] POINTS_12AX = 5'h08;
    localparam logic [3:0] DRIVERS_6AX = 4'h6;
    localparam logic [3:0] DRIVERS_12AX = 4'hc;
    localparam logic [2:0] IDX_GATEWAY = 3'h6;
    localparam logic [2:0] IDX_SYSTEM = 3'h7;
    localparam int IO_WORD_SHIFT = 3;
    localparam logic [15:0] CMD_CONN0 = 16'h1d80;
    localparam logic [15:0] CMD_NV_BATCH = 16'h3e85;
    localparam int CLK_NS = 20;
    localparam int SETTLE_NS = 100;
    localparam logic [2:0] SETTLE_CYCLES = 3'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
    localparam int SW_BITS = 23;
    localparam logic [7:0] OFS_RY = 8'h00;
    localparam logic [7:0] OFS_RX = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_CMD_DATA = 8'h0c;
    localparam logic [7:0] OFS_INFO = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFS_FAULT = 8'h1c;
    localparam int IRQ_CMD = 0;
    localparam int IRQ_RX = 1;
    localparam int IRQ_ALARM = 2;
    localparam int IRQ_W = 3;
    typedef enum logic [1:0] {
        BOOT_HOLD = 2'b00,
        BOOT_SETTLE = 2'b01,
        BOOT_RUN = 2'b11
    } boot_e;
endpackage : gw_cfg_pkg

// ---- common/gw_link_if.sv ----
// Link between the gateway end and the master end.
// Assumes both ends are clocked by the same MCLK.
`timescale 1ns/1ps
interface gw_link_if;
    logic ry_valid;
    logic ry_ready;
    logic [2:0] ry_index;
    logic [15:0] ry_bits;
    logic rx_valid;
    logic [2:0] rx_index;
    logic [15:0] rx_bits;
    logic cmd_valid;
    logic [15:0] cmd_code;
    logic [15:0] cmd_data;
    logic cmd_done;
    logic cmd_ok;
    logic link_fault;
    logic [6:0] station;
    logic [9:0] io_base;
    logic cfg_ok;
    logic axis12;
    logic sw_alarm;
    modport gateway(input ry_valid, ry_index, ry_bits, cmd_valid, cmd_code, cmd_data,
        link_fault, output ry_ready, rx_valid, rx_index, rx_bits, cmd_done, cmd_ok,
        station, io_base, cfg_ok, axis12, sw_alarm);
    modport master(output ry_valid, ry_index, ry_bits, cmd_valid, cmd_code, cmd_data,
        link_fault, input ry_ready, rx_valid, rx_index, rx_bits, cmd_done, cmd_ok,
        station, io_base, cfg_ok, axis12, sw_alarm);
endinterface : gw_link_if

// ---- hdl/gw_sync3.sv ----
// Three-stage synchroniser for one pin input.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module gw_sync3 (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic s1;
    logic s2;
    logic s3;
    logic next_q;

    // Change accepted once stages two and three agree
    always_comb begin
        next_q = (s2 == s3) ? s3 : q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q <= 1'b0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end
endmodule : gw_sync3

// ---- hdl/gw_master.sv ----
// Master end: APB register slave that drives the gateway link.
// Assumes APB on MCLK and a gateway end on the same clock.
`timescale 1ns/1ps
module gw_master
    import gw_cfg_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    gw_link_if.master LINK
);
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= OFS_FAULT);
    endfunction : mapped

    logic done;
    logic wr;
    logic ry_busy;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic next_pready;
    logic [15:0] cmd_data;
    logic [15:0] next_cmd_data;
    logic [15:0] next_cmd_code;
    logic next_cmd_valid;
    logic next_ry_valid;
    logic [2:0] next_ry_index;
    logic [15:0] next_ry_bits;
    logic [IRQ_W-1:0] stat;
    logic [IRQ_W-1:0] mask;
    logic [IRQ_W-1:0] next_stat;
    logic [IRQ_W-1:0] next_mask;
    logic next_fault;

    assign done = PSEL && PENABLE && PREADY;
    assign wr = done && PWRITE && !PSLVERR;
    // Refuse new master bits while one is pending or the station is invalid
    assign ry_busy = LINK.ry_valid || !LINK.cfg_ok; // [RL9]

    always_comb begin
        next_pready = PSEL && PENABLE && !PREADY;
        next_prdata = 32'h0000_0000;
        next_pslverr = !mapped(PADDR);
        if (PADDR == OFS_RY) begin
            next_pslverr = PWRITE && ry_busy;
        end else if (PADDR == OFS_RX) begin
            next_prdata = {13'h0000, LINK.rx_index, LINK.rx_bits};
        end else if (PADDR == OFS_CMD) begin
            next_prdata = {16'h0000, LINK.cmd_code};
        end else if (PADDR == OFS_CMD_DATA) begin
            next_prdata = {16'h0000, cmd_data};
        end else if (PADDR == OFS_INFO) begin
            next_prdata = {12'h000, LINK.sw_alarm, LINK.axis12, LINK.cfg_ok,
                LINK.io_base, LINK.station};
        end else if (PADDR == OFS_IRQ_STAT) begin
            next_prdata = {29'h0, stat};
        end else if (PADDR == OFS_IRQ_MASK) begin
            next_prdata = {29'h0, mask};
        end else if (PADDR == OFS_FAULT) begin
            next_prdata = {31'h0, LINK.link_fault};
        end
        if (!next_pready || PWRITE) begin
            next_prdata = 32'h0000_0000;
        end
        if (!next_pready) begin
            next_pslverr = 1'b0;
        end
        next_ry_valid = LINK.ry_valid && !LINK.ry_ready;
        next_ry_index = LINK.ry_index;
        next_ry_bits = LINK.ry_bits;
        next_cmd_valid = 1'b0;
        next_cmd_code = LINK.cmd_code;
        next_cmd_data = cmd_data;
        next_mask = mask;
        next_fault = LINK.link_fault;
        next_stat = stat;
        if (wr && PADDR == OFS_RY) begin
            next_ry_valid = 1'b1;
            next_ry_index = PWDATA[18:16];
            next_ry_bits = PWDATA[15:0];
        end
        if (wr && PADDR == OFS_CMD) begin
            next_cmd_valid = 1'b1; // [RL15]
            next_cmd_code = PWDATA[15:0];
        end
        if (wr && PADDR == OFS_CMD_DATA) begin
            next_cmd_data = PWDATA[15:0];
        end
        if (wr && PADDR == OFS_IRQ_MASK) begin
            next_mask = PWDATA[IRQ_W-1:0];
        end
        if (wr && PADDR == OFS_FAULT) begin
            next_fault = PWDATA[0]; // [RL16]
        end
        if (wr && PADDR == OFS_IRQ_STAT) begin
            next_stat = stat & ~PWDATA[IRQ_W-1:0];
        end
        // Set wins over a clear in the same cycle
        next_stat[IRQ_CMD] = next_stat[IRQ_CMD] | LINK.cmd_done;
        next_stat[IRQ_RX] = next_stat[IRQ_RX] | LINK.rx_valid;
        next_stat[IRQ_ALARM] = next_stat[IRQ_ALARM] | LINK.sw_alarm; // [RL2]
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
            LINK.ry_valid <= 1'b0;
            LINK.ry_index <= 3'h0;
            LINK.ry_bits <= 16'h0000;
            LINK.cmd_valid <= 1'b0;
            LINK.cmd_code <= 16'h0000;
            LINK.cmd_data <= 16'h0000;
            LINK.link_fault <= 1'b0;
            cmd_data <= 16'h0000;
            stat <= '0;
            mask <= '0;
            IRQ <= 1'b0;
        end else begin
            PREADY <= next_pready;
            PRDATA <= next_prdata;
            PSLVERR <= next_pslverr;
            LINK.ry_valid <= next_ry_valid;
            LINK.ry_index <= next_ry_index;
            LINK.ry_bits <= next_ry_bits;
            LINK.cmd_valid <= next_cmd_valid;
            LINK.cmd_code <= next_cmd_code;
            LINK.cmd_data <= next_cmd_data;
            LINK.link_fault <= next_fault;
            cmd_data <= next_cmd_data;
            stat <= next_stat;
            mask <= next_mask;
            IRQ <= |(next_stat & next_mask);
        end
    end
endmodule : gw_master

// ---- sim/gw_link_chk.sv ----
// Checker for the link between gateway end and master end.
// Assumes one clock MCLK and asynchronous active-high SYS_RST.
`timescale 1ns/1ps
module gw_link_chk
    import gw_cfg_pkg::*;
(
    input wire logic MCLK, SYS_RST, ry_valid, ry_ready, rx_valid,
    input wire logic [2:0] ry_index, rx_index,
    input wire logic cmd_valid, cmd_done, cmd_ok, cfg_ok, axis12, sw_alarm,
    input wire logic [15:0] cmd_code,
    input wire logic [6:0] station,
    input wire logic [9:0] io_base
);
    logic [3:0] age;
    logic [3:0] next_age;
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // Cycles since reset, saturating
    always_comb begin
        next_age = (age == 4'hf) ? age : age + 4'h1;
    end
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST)
            age <= 4'h0;
        else
            age <= next_age;
    end
    sequence s_take;
        ry_valid && ry_ready;
    endsequence
    sequence s_known;
        cmd_valid && (cmd_code == CMD_CONN0 || cmd_code == CMD_NV_BATCH);
    endsequence
    AST_RX_ANS: assert property (s_take |=> rx_valid)
        else $error("no response after a taken word");
    AST_RX_IDX: assert property (s_take |=> rx_index == $past(ry_index))
        else $error("response index differs from request");
    AST_GAP12: assert property (s_take ##0 (axis12 && ry_index < 3'h6) |=> !ry_ready)
        else $error("ready during upper byte in 12-axis mode");
    AST_RDY_CFG: assert property (ry_ready |-> cfg_ok)
        else $error("ready with invalid station");
    AST_STN: assert property (cfg_ok |-> station >= STATION_MIN && station <= STATION_MAX)
        else $error("station out of range but valid");
    AST_BASE: assert property (cfg_ok |-> io_base == {station - 7'h01, 3'h0})
        else $error("io base does not follow station");
    AST_HOLD: assert property (age == 4'hf |-> $stable(station) && $stable(axis12)
        && $stable(sw_alarm) && $stable(cfg_ok))
        else $error("latched setting changed");
    AST_DONE: assert property (cmd_valid |=> cmd_done)
        else $error("command not answered");
    AST_OK: assert property (s_known |=> cmd_ok)
        else $error("known command not accepted");
endmodule : gw_link_chk

// ---- sim/testbench.sv ----
// Bench: gateway end and master end joined by the link, driven over APB.
// Assumes MCLK of 20 ns and SYS_RST asynchronous active high.
`timescale 1ns/1ps
module testbench
    import gw_cfg_pkg::*;
;
    logic MCLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, err, irq1;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [3:0] SERIAL_RATE_SW, AXIS_MODE_SW, STATION_TENS_SW, STATION_ONES_SW, FIELD_RATE_SW;
    logic TERMINATION_SW, RS485_ERR, NV_CONN_IN, SERIAL_RATE_OK, SWITCH_ALARM, AXIS12_MODE;
    logic STATION_OK, FIELD_RATE_OK, TERM_EN, CONN_EN0, CONFIG_DONE, DRV_WR, NV_WRITE;
    logic NV_CONN_OUT, SERIAL_ERR_LED, LINK_ERR_LED;
    logic [15:0] DRV_STATUS, DRV_BITS, GW_CTRL;
    logic [3:0] MAX_DRIVERS, DRV_ADDR;
    logic [4:0] POINTS_PER_DRIVER;
    logic [6:0] STATION_NUM;
    logic [2:0] FIELD_RATE;
    logic [19:0] tbl [6] = '{20'h70010, 20'h8e641, 20'h31652, 20'hf0003, 20'h71124, 20'h00995};
    int errors, compares, cyc;
    gw_link_if link();
    gw_gateway gw_gateway_inst (.MCLK, .SYS_RST, .LINK(link), .SERIAL_RATE_SW, .AXIS_MODE_SW,
        .STATION_TENS_SW, .STATION_ONES_SW, .FIELD_RATE_SW, .TERMINATION_SW, .RS485_ERR,
        .NV_CONN_IN, .DRV_STATUS, .SERIAL_RATE_OK, .SWITCH_ALARM, .AXIS12_MODE, .MAX_DRIVERS,
        .POINTS_PER_DRIVER, .STATION_NUM, .STATION_OK, .FIELD_RATE, .FIELD_RATE_OK, .TERM_EN,
        .CONN_EN0, .CONFIG_DONE, .DRV_WR, .DRV_ADDR, .DRV_BITS, .GW_CTRL, .NV_WRITE,
        .NV_CONN_OUT, .SERIAL_ERR_LED, .LINK_ERR_LED);
    gw_master gw_master_inst (.MCLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .IRQ, .LINK(link));
    gw_link_chk gw_link_chk_inst (.MCLK, .SYS_RST, .ry_valid(link.ry_valid),
        .ry_ready(link.ry_ready), .rx_valid(link.rx_valid), .ry_index(link.ry_index),
        .rx_index(link.rx_index), .cmd_valid(link.cmd_valid), .cmd_done(link.cmd_done),
        .cmd_ok(link.cmd_ok), .cfg_ok(link.cfg_ok), .axis12(link.axis12),
        .sw_alarm(link.sw_alarm), .cmd_code(link.cmd_code), .station(link.station),
        .io_base(link.io_base));
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask : wt
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do @(posedge MCLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    // Power cycle with new switch settings, then check the latched view
    task automatic boot(input logic [19:0] e, input logic nv);
        logic [6:0] st;
        logic ok;
        {SERIAL_RATE_SW, AXIS_MODE_SW, STATION_TENS_SW, STATION_ONES_SW, FIELD_RATE_SW} <= e;
        {NV_CONN_IN, TERMINATION_SW} <= {nv, 1'b1};
        st = 7'(e[11:8]) * 7'd10 + 7'(e[7:4]);
        ok = e[11:8] <= 4'h9 && e[7:4] <= 4'h9 && st >= 7'd1 && st <= 7'd64;
        repeat (2) @(posedge MCLK);
        SYS_RST <= 1'b1;
        repeat (3) @(posedge MCLK);
        SYS_RST <= 1'b0;
        wt(12);
        chk({SERIAL_RATE_OK, SWITCH_ALARM}, {e[19:16] == 4'h7, e[19:16] >= 4'h8});
        chk({AXIS12_MODE, MAX_DRIVERS, POINTS_PER_DRIVER},
            e[12] ? {1'b1, 4'hc, 5'h08} : {1'b0, 4'h6, 5'h10});
        chk({STATION_NUM, STATION_OK}, {st, ok});
        chk({FIELD_RATE, FIELD_RATE_OK}, {e[2:0], e[3:0] <= 4'h4});
        chk({TERM_EN, CONN_EN0, CONFIG_DONE}, {1'b1, nv, 1'b1});
        apb(1'b0, OFS_INFO, 32'h0);
        chk(rd[19:17], {e[19:16] >= 4'h8, e[12], ok});
        if (ok) chk(rd[16:0], {st - 7'h01, 3'h0, st});
        SERIAL_RATE_SW <= ~e[19:16];
        AXIS_MODE_SW <= ~e[15:12];
        STATION_ONES_SW <= e[7:4] + 4'h1;
        wt(10);
        chk({SWITCH_ALARM, AXIS12_MODE, STATION_NUM}, {e[19:16] >= 4'h8, e[12], st});
        apb(1'b1, OFS_RY, {13'h0, 3'h2, 16'ha5c3});
        if (!ok) chk(err, 1'b1);
        if (ok) begin
            for (int n = 0; n < 20 && DRV_WR !== 1'b1; n++) wt(1);
            chk({DRV_WR, DRV_ADDR, DRV_BITS},
                {1'b1, e[12] ? {4'h4, 16'h00c3} : {4'h2, 16'ha5c3}});
            wt(1);
            if (e[12]) chk({DRV_WR, DRV_ADDR, DRV_BITS}, {1'b1, 4'h5, 16'h00a5});
            apb(1'b0, OFS_RX, 32'h0);
            chk(rd, {13'h0, 3'h2, 16'h5a3c});
            apb(1'b1, OFS_RY, {13'h0, 3'h6, 16'h1234});
            wt(10);
            chk(GW_CTRL, 16'h1234);
        end
    endtask : boot
    // Commands, error indicators, interrupt and an unmapped access
    task automatic extras();
        apb(1'b1, OFS_CMD_DATA, 32'h1);
        apb(1'b1, OFS_CMD, {16'h0, CMD_CONN0});
        apb(1'b1, OFS_CMD, {16'h0, CMD_NV_BATCH});
        wt(1);
        chk({NV_WRITE, NV_CONN_OUT, CONN_EN0}, 3'b110);
        apb(1'b1, OFS_FAULT, 32'h1);
        wt(8);
        chk({SERIAL_ERR_LED, LINK_ERR_LED}, 2'b01);
        apb(1'b1, OFS_FAULT, 32'h0);
        RS485_ERR <= 1'b1;
        wt(8);
        chk({SERIAL_ERR_LED, LINK_ERR_LED}, 2'b10);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        RS485_ERR <= 1'b0;
        chk(rd[0], 1'b1);
        apb(1'b1, OFS_IRQ_MASK, 32'h7);
        wt(3);
        irq1 = IRQ;
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        wt(3);
        chk({irq1, IRQ}, 2'b10);
        apb(1'b1, OFS_IRQ_STAT, 32'h7);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk({rd[2:0], IRQ}, 4'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk(err, 1'b1);
    endtask : extras
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, RS485_ERR} = '0;
        DRV_STATUS = 16'h5a3c;
        SYS_RST = 1'b1;
        for (int i = 0; i < 6; i++) begin
            boot(tbl[i], i[0]);
            if (i == 0) extras();
        end
        print_verdict();
    end
endmodule : testbench
